/* File: nvmpc_defs.svh */
// Constants of the nonvolatile program control block: register indices, bit positions,
// reset values and reset hold counts.
// Assumes it is included by its bare name, after the package, by the design file.
`ifndef NVMPC_DEFS_SVH
`define NVMPC_DEFS_SVH

// ****************************************************************
// Register indices; the byte address on the bus is four times the index.
// ****************************************************************
`define NVMPC_IDX_CTRL 16'h0007
`define NVMPC_IDX_OPTION 16'h7fde
`define NVMPC_IDX_EP_ADDR 16'h0020
`define NVMPC_IDX_EP_DATA 16'h0021
`define NVMPC_IDX_EE_ADDR 16'h0022
`define NVMPC_IDX_EE_DATA 16'h0023

// ****************************************************************
// Control register bit positions.
// ****************************************************************
`define NVMPC_BIT_EP_LATCH 5
`define NVMPC_BIT_EP_PROG 4
`define NVMPC_BIT_EE_ERASE 2
`define NVMPC_BIT_EE_LATCH 1
`define NVMPC_BIT_EE_PUMP 0

// ****************************************************************
// Option byte bit position and reset hold counts in clock cycles.
// ****************************************************************
`define NVMPC_BIT_OPT_POR_HOLD 4
`define NVMPC_POR_HOLD_SHORT 12'd16
`define NVMPC_POR_HOLD_LONG 12'd4064

// ****************************************************************
// Reset and data values.
// ****************************************************************
`define NVMPC_ERASED_BYTE 8'h00
`define NVMPC_GARBAGE_BYTE 8'hff
`define NVMPC_ADDR_RST 16'h0000

`endif

/* File: nvmpc_pkg.sv */
// Types of the nonvolatile program control block.
// Assumes nothing of its surroundings; every user names items with the package prefix.
package nvmpc_pkg;

  // ****************************************************************
  // State machines of the two arrays, one-hot.
  // ****************************************************************
  typedef enum logic [2:0] {
    NVMPC_EP_READ = 3'b001,
    NVMPC_EP_LOAD = 3'b010,
    NVMPC_EP_PROG = 3'b100
  } nvmpc_ep_state_t;

  typedef enum logic [4:0] {
    NVMPC_EE_READ = 5'b00001,
    NVMPC_EE_LOAD_PROG = 5'b00010,
    NVMPC_EE_PROG = 5'b00100,
    NVMPC_EE_LOAD_ERASE = 5'b01000,
    NVMPC_EE_ERASE = 5'b10000
  } nvmpc_ee_state_t;

  // Visible control bits, decoded from the two state machines.
  typedef struct packed {
    logic ep_latch;
    logic ep_prog;
    logic ee_erase;
    logic ee_latch;
    logic ee_pump;
  } nvmpc_ctrl_t;

  // Captured EEPROM target handed to the array.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } nvmpc_ee_target_t;

endpackage

/* File: nvmpc_top.sv */
// Program and erase control for the on-chip EPROM and byte-erasable EEPROM, with a
// read-only option byte that sets the power-on reset hold time.
// Assumes a classic Wishbone master on clk_i, arrays that answer reads combinationally,
// and stop, power-on and pin reset events that come from outside the clock domain.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`include "nvmpc_defs.svh"

module nvmpc_top #(
  parameter int ADDR_W = 18
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic stop_i,
  input wire logic por_i,
  input wire logic ext_reset_i,
  input wire logic [7:0] option_byte_i,
  input wire logic [7:0] eprom_rdata_i,
  input wire logic [7:0] eeprom_rdata_i,
  output logic [15:0] eprom_rd_addr_o,
  output logic eprom_vector_ok_o,
  output logic eprom_program_enable_o,
  output logic [15:0] eprom_prog_addr_o,
  output logic [127:0] eprom_prog_data_o,
  output logic eeprom_pump_enable_o,
  output logic eeprom_erase_select_o,
  output nvmpc_pkg::nvmpc_ee_target_t eeprom_target_o,
  output logic por_hold_time_select_o,
  output logic [11:0] por_hold_cycles_o
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  nvmpc_pkg::nvmpc_ep_state_t ep_state_q;
  nvmpc_pkg::nvmpc_ee_state_t ee_state_q;
  nvmpc_pkg::nvmpc_ctrl_t ctrl;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic clr_evt;
  logic ack_q;
  logic req;
  logic [15:0] idx;
  logic ctrl_wr;
  logic ep_data_wr;
  logic ee_data_wr;
  logic [15:0] ep_addr_q;
  logic [15:0] ee_addr_q;
  logic [11:0] ep_group_q;
  logic ep_loaded_q;
  logic [7:0] ep_buf_q [16];
  logic ee_captured_q;
  logic ee_has_target;
  nvmpc_pkg::nvmpc_ee_target_t ee_target_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [11:0] hold_q;

  // Word index of a byte address; every register sits in the low 16 bits of one word.
  function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] adr);
    word_index = adr[17:2];
  endfunction

  // Updates either or both bytes of a 16-bit register under two byte lanes.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [1:0] sel,
                                          input logic [15:0] wdat);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wdat[15:8];
    end
  endfunction

  // ****************************************************************
  // Event synchronisers; the pins and STOP come from outside this clock.
  // ****************************************************************
  // A stretched or repeated event only clears the latches again, so no edge detect is needed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 3'b000;
      sync2_q <= 3'b000;
    end else if (ce_i) begin
      sync1_q <= {stop_i, por_i, ext_reset_i};
      sync2_q <= sync1_q;
    end
  end

  assign clr_evt = |sync2_q;

  // ****************************************************************
  // Wishbone slave: one wait state, every access answered.
  // ****************************************************************
  // Each access is acknowledged one cycle after it is seen; ack drops the cycle after.
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign idx = word_index(wb_adr_i);
  assign ctrl_wr = req && wb_we_i && wb_sel_i[0] && (idx == `NVMPC_IDX_CTRL);
  assign ep_data_wr = req && wb_we_i && wb_sel_i[0] && (idx == `NVMPC_IDX_EP_DATA);
  assign ee_data_wr = req && wb_we_i && wb_sel_i[0] && (idx == `NVMPC_IDX_EE_DATA);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req;
    end
  end

  assign wb_ack_o = ack_q;

  // ****************************************************************
  // Visible control bits.
  // ****************************************************************
  // The bit pairs are pure decodes of the states, so illegal combinations cannot exist.
  always_comb begin
    ctrl.ep_latch = (ep_state_q != nvmpc_pkg::NVMPC_EP_READ);
    ctrl.ep_prog = (ep_state_q == nvmpc_pkg::NVMPC_EP_PROG);
    ctrl.ee_latch = (ee_state_q != nvmpc_pkg::NVMPC_EE_READ);
    ctrl.ee_pump = (ee_state_q == nvmpc_pkg::NVMPC_EE_PROG) ||
                   (ee_state_q == nvmpc_pkg::NVMPC_EE_ERASE);
    ctrl.ee_erase = (ee_state_q == nvmpc_pkg::NVMPC_EE_LOAD_ERASE) ||
                    (ee_state_q == nvmpc_pkg::NVMPC_EE_ERASE);
  end

  // ****************************************************************
  // EPROM state machine.
  // ****************************************************************
  // STOP and resets win over any software write in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep_state_q <= nvmpc_pkg::NVMPC_EP_READ;
    end else if (ce_i) begin
      if (clr_evt) begin
        ep_state_q <= nvmpc_pkg::NVMPC_EP_READ;
      end else if (ctrl_wr) begin
        case (ep_state_q)
          nvmpc_pkg::NVMPC_EP_READ: begin
            if (wb_dat_i[`NVMPC_BIT_EP_LATCH]) begin
              ep_state_q <= nvmpc_pkg::NVMPC_EP_LOAD;
            end
          end
          nvmpc_pkg::NVMPC_EP_LOAD: begin
            if (!wb_dat_i[`NVMPC_BIT_EP_LATCH]) begin
              ep_state_q <= nvmpc_pkg::NVMPC_EP_READ;
            end else if (wb_dat_i[`NVMPC_BIT_EP_PROG] && ep_loaded_q) begin
              ep_state_q <= nvmpc_pkg::NVMPC_EP_PROG;
            end
          end
          nvmpc_pkg::NVMPC_EP_PROG: begin
            // A zero in the program bit alone leaves programming running.
            if (!wb_dat_i[`NVMPC_BIT_EP_LATCH]) begin
              ep_state_q <= nvmpc_pkg::NVMPC_EP_READ;
            end
          end
          default: begin
            ep_state_q <= nvmpc_pkg::NVMPC_EP_READ;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // EPROM address and sixteen-byte latch.
  // ****************************************************************
  // The first byte fixes the group; bytes outside it are dropped rather than corrupting it.
  // Read mode holds every lane of the buffer at the erased value, so lanes that
  // software never loads program nothing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep_addr_q <= `NVMPC_ADDR_RST;
      ep_group_q <= 12'h000;
      ep_loaded_q <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        ep_buf_q[i] <= `NVMPC_ERASED_BYTE;
      end
    end else if (ce_i) begin
      if (req && wb_we_i && (idx == `NVMPC_IDX_EP_ADDR)) begin
        ep_addr_q <= merge16(ep_addr_q, wb_sel_i[1:0], wb_dat_i[15:0]);
      end
      if (!ctrl.ep_latch) begin
        ep_loaded_q <= 1'b0;
        for (int i = 0; i < 16; i++) begin
          ep_buf_q[i] <= `NVMPC_ERASED_BYTE;
        end
      end else if (ep_data_wr && (ep_state_q == nvmpc_pkg::NVMPC_EP_LOAD)) begin
        if (!ep_loaded_q || (ep_addr_q[15:4] == ep_group_q)) begin
          ep_group_q <= ep_addr_q[15:4];
          ep_loaded_q <= 1'b1;
          ep_buf_q[ep_addr_q[3:0]] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // ****************************************************************
  // EEPROM state machine.
  // ****************************************************************
  // The capture flag lags the latch by one cycle after a clear, so it only counts while
  // the latch is set; a stale flag would otherwise start the pump or block a reload.
  assign ee_has_target = ee_captured_q && ctrl.ee_latch;

  // Erase select may move between the two load states only until a target is captured.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ee_state_q <= nvmpc_pkg::NVMPC_EE_READ;
    end else if (ce_i) begin
      if (clr_evt) begin
        ee_state_q <= nvmpc_pkg::NVMPC_EE_READ;
      end else if (ctrl_wr) begin
        if (!wb_dat_i[`NVMPC_BIT_EE_LATCH]) begin
          ee_state_q <= nvmpc_pkg::NVMPC_EE_READ;
        end else begin
          case (ee_state_q)
            nvmpc_pkg::NVMPC_EE_READ,
            nvmpc_pkg::NVMPC_EE_LOAD_PROG,
            nvmpc_pkg::NVMPC_EE_LOAD_ERASE: begin
              if (ee_has_target && wb_dat_i[`NVMPC_BIT_EE_PUMP]) begin
                ee_state_q <= (ee_state_q == nvmpc_pkg::NVMPC_EE_LOAD_ERASE) ?
                              nvmpc_pkg::NVMPC_EE_ERASE : nvmpc_pkg::NVMPC_EE_PROG;
              end else if (!ee_has_target) begin
                ee_state_q <= wb_dat_i[`NVMPC_BIT_EE_ERASE] ?
                              nvmpc_pkg::NVMPC_EE_LOAD_ERASE :
                              nvmpc_pkg::NVMPC_EE_LOAD_PROG;
              end
            end
            nvmpc_pkg::NVMPC_EE_PROG,
            nvmpc_pkg::NVMPC_EE_ERASE: begin
              ee_state_q <= ee_state_q;
            end
            default: begin
              ee_state_q <= nvmpc_pkg::NVMPC_EE_READ;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // EEPROM address and target capture.
  // ****************************************************************
  // A data write while loading captures the address register and the byte as one target.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ee_addr_q <= `NVMPC_ADDR_RST;
      ee_captured_q <= 1'b0;
      ee_target_q <= '0;
    end else if (ce_i) begin
      if (req && wb_we_i && (idx == `NVMPC_IDX_EE_ADDR)) begin
        ee_addr_q <= merge16(ee_addr_q, wb_sel_i[1:0], wb_dat_i[15:0]);
      end
      if (!ctrl.ee_latch) begin
        ee_captured_q <= 1'b0;
      end else if (ee_data_wr && !ctrl.ee_pump) begin
        ee_captured_q <= 1'b1;
        ee_target_q.addr <= ee_addr_q;
        ee_target_q.data <= wb_dat_i[7:0];
      end
    end
  end

  // ****************************************************************
  // Read data.
  // ****************************************************************
  // Array reads bypass the latch contents; while latched the EPROM answers a fixed pattern.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (idx)
      `NVMPC_IDX_CTRL: begin
        rdata_d[`NVMPC_BIT_EP_LATCH] = ctrl.ep_latch;
        rdata_d[`NVMPC_BIT_EP_PROG] = ctrl.ep_prog;
        rdata_d[`NVMPC_BIT_EE_ERASE] = ctrl.ee_erase;
        rdata_d[`NVMPC_BIT_EE_LATCH] = ctrl.ee_latch;
        rdata_d[`NVMPC_BIT_EE_PUMP] = ctrl.ee_pump;
      end
      `NVMPC_IDX_OPTION: begin
        rdata_d[7:0] = option_byte_i;
      end
      `NVMPC_IDX_EP_ADDR: begin
        rdata_d[15:0] = ep_addr_q;
      end
      `NVMPC_IDX_EP_DATA: begin
        rdata_d[7:0] = ctrl.ep_latch ? `NVMPC_GARBAGE_BYTE : eprom_rdata_i;
      end
      `NVMPC_IDX_EE_ADDR: begin
        rdata_d[15:0] = ee_addr_q;
      end
      `NVMPC_IDX_EE_DATA: begin
        rdata_d[7:0] = ctrl.ee_latch ? `NVMPC_GARBAGE_BYTE : eeprom_rdata_i;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce_i && req && !wb_we_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign wb_dat_o = rdata_q;

  // ****************************************************************
  // Power-on reset hold time from the option byte.
  // ****************************************************************
  // The option byte is never reset; only the derived count is, and it follows the byte.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= `NVMPC_POR_HOLD_LONG;
    end else if (ce_i) begin
      hold_q <= option_byte_i[`NVMPC_BIT_OPT_POR_HOLD] ?
                `NVMPC_POR_HOLD_SHORT : `NVMPC_POR_HOLD_LONG;
    end
  end

  // ****************************************************************
  // Array-side outputs.
  // ****************************************************************
  // Vectors are only fetched while the array is in plain read mode.
  assign eprom_vector_ok_o = !ctrl.ep_latch;
  assign eprom_rd_addr_o = ep_addr_q;
  assign eprom_program_enable_o = ctrl.ep_prog;
  assign eprom_prog_addr_o = {ep_group_q, 4'h0};
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      eprom_prog_data_o[i*8 +: 8] = ep_buf_q[i];
    end
  end
  assign eeprom_pump_enable_o = ctrl.ee_pump;
  assign eeprom_erase_select_o = ctrl.ee_erase;
  assign eeprom_target_o = ee_target_q;
  assign por_hold_time_select_o = option_byte_i[`NVMPC_BIT_OPT_POR_HOLD];
  assign por_hold_cycles_o = hold_q;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_prog_needs_latch: assert property ($rose(eprom_program_enable_o) |->
    $past(ce_i && ctrl.ep_latch && ctrl_wr && wb_dat_i[`NVMPC_BIT_EP_LATCH]))
    else $error("EPROM program enable set without latch");
  chk_latched_read_data: assert property ((ce_i && req && !wb_we_i && ctrl.ep_latch &&
    idx == `NVMPC_IDX_EP_DATA) |=> wb_ack_o && wb_dat_o[7:0] == `NVMPC_GARBAGE_BYTE)
    else $error("latched EPROM read returned array data");
  chk_vector_block: assert property ((ce_i && !clr_evt && ctrl_wr &&
    wb_dat_i[`NVMPC_BIT_EP_LATCH]) |=> !eprom_vector_ok_o)
    else $error("vector fetch allowed while EPROM latched");
  chk_ep_clear_evt: assert property ((ce_i && clr_evt) |=> !ctrl.ep_latch)
    else $error("EPROM latch survived STOP or reset");
  chk_group_kept: assert property ((ce_i && ep_loaded_q && ctrl.ep_latch && ep_data_wr &&
    ep_addr_q[15:4] != ep_group_q) |=> $stable(ep_group_q))
    else $error("EPROM group changed by out-of-group byte");
  chk_prog_needs_byte: assert property ($rose(ctrl.ep_prog) |-> $past(ep_loaded_q))
    else $error("EPROM programming started with no byte loaded");
  chk_prog_sticky: assert property ((ce_i && ctrl.ep_prog && !clr_evt &&
    !(ctrl_wr && !wb_dat_i[`NVMPC_BIT_EP_LATCH])) |=> ctrl.ep_prog)
    else $error("EPROM program enable cleared by software");
  chk_erase_locked: assert property ((ce_i && ee_has_target && !clr_evt &&
    !(ctrl_wr && !wb_dat_i[`NVMPC_BIT_EE_LATCH])) |=> $stable(ctrl.ee_erase))
    else $error("erase select changed after capture");
  chk_latch_clears_all: assert property ((ce_i && ctrl_wr &&
    !wb_dat_i[`NVMPC_BIT_EE_LATCH]) |=> !eeprom_pump_enable_o && !eeprom_erase_select_o)
    else $error("EEPROM bits set with latch clear");
  chk_pump_needs_data: assert property (ctrl.ee_pump |-> ee_captured_q)
    else $error("charge pump on before data captured");
  chk_ee_clear_evt: assert property ((ce_i && clr_evt) |=> !ctrl.ee_latch ##1 !ctrl.ee_pump)
    else $error("EEPROM latch survived STOP or reset");
  chk_hold_count: assert property (ce_i |=> por_hold_cycles_o ==
    ($past(option_byte_i[`NVMPC_BIT_OPT_POR_HOLD]) ? `NVMPC_POR_HOLD_SHORT :
    `NVMPC_POR_HOLD_LONG))
    else $error("reset hold count does not follow option bit");

endmodule

/* File: test_eprom_eeprom_program_control.sv */
// Self-checking testbench for the nonvolatile program control block.
// Assumes the design file and its package are compiled first; assertions live in the design.
`timescale 1ns/10ps

module test_eprom_eeprom_program_control;

  // ****************************************************************
  // Bench signals and register map.
  // ****************************************************************
  localparam logic [17:0] CTRL = 18'h0001c;
  localparam logic [17:0] OPT = 18'h1ff78;
  localparam logic [17:0] EPA = 18'h00080;
  localparam logic [17:0] EPD = 18'h00084;
  localparam logic [17:0] EEA = 18'h00088;
  localparam logic [17:0] EED = 18'h0008c;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic stop_i, por_i, ext_reset_i, eprom_vector_ok_o, eprom_program_enable_o;
  logic eeprom_pump_enable_o, eeprom_erase_select_o, por_hold_time_select_o;
  logic [17:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0] option_byte_i, eprom_rdata_i, eeprom_rdata_i;
  logic [15:0] eprom_rd_addr_o, eprom_prog_addr_o;
  logic [127:0] eprom_prog_data_o;
  nvmpc_pkg::nvmpc_ee_target_t eeprom_target_o;
  logic [11:0] por_hold_cycles_o;
  int num_errors = 0;
  int samples_checked = 0;

  nvmpc_top u_nvmpc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_i(stop_i),
    .por_i(por_i), .ext_reset_i(ext_reset_i), .option_byte_i(option_byte_i),
    .eprom_rdata_i(eprom_rdata_i), .eeprom_rdata_i(eeprom_rdata_i),
    .eprom_rd_addr_o(eprom_rd_addr_o), .eprom_vector_ok_o(eprom_vector_ok_o),
    .eprom_program_enable_o(eprom_program_enable_o), .eprom_prog_addr_o(eprom_prog_addr_o),
    .eprom_prog_data_o(eprom_prog_data_o), .eeprom_pump_enable_o(eeprom_pump_enable_o),
    .eeprom_erase_select_o(eeprom_erase_select_o), .eeprom_target_o(eeprom_target_o),
    .por_hold_time_select_o(por_hold_time_select_o), .por_hold_cycles_o(por_hold_cycles_o));

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 clk_i = ~clk_i;

  // ****************************************************************
  // Expectation functions and bus tasks.
  // ****************************************************************
  // Control register image from its five visible bits.
  function automatic logic [31:0] cv(input logic el, ep, er, ll, pp);
    cv = {26'h0, el, ep, 1'b0, er, ll, pp};
  endfunction

  // Reset hold length chosen by the option bit.
  function automatic logic [11:0] hold_exp(input logic [7:0] ob);
    hold_exp = ob[4] ? 12'h010 : 12'hfe0;
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high, bounded by a timeout.
  task automatic wb(input logic we, input logic [17:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: bus answer timed out", $time);
      summarize();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [17:0] a, input logic [31:0] exp, input string m);
    wb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    int i;
    int e;
    logic [15:0] ga, a;
    logic [7:0] d, ob, rv;
    logic [127:0] pd;
    clk_i = 0; rst_i = 1; ce_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0;
    wb_adr_i = 0; wb_sel_i = 0; wb_dat_i = 0; stop_i = 0; por_i = 0; ext_reset_i = 0;
    option_byte_i = 8'h10; eprom_rdata_i = 8'h00; eeprom_rdata_i = 8'h00;
    i = $urandom(15000);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state, option byte and hold time for both settings of the option bit.
    rdchk(CTRL, 32'h0, "ctrl after reset");
    for (e = 0; e < 2; e++) begin
      ob = $urandom;
      ob[4] = e[0];
      option_byte_i <= ob;
      repeat (2) @(posedge clk_i);
      chk(por_hold_time_select_o, e[0], "hold select");
      chk(por_hold_cycles_o, hold_exp(ob), "hold count");
      wr(OPT, {24'h0, ~ob});
      rdchk(OPT, {24'h0, ob}, "option byte");
    end
    rdchk(18'h000f0, 32'h0, "unmapped read");
    $display("test option done");
    // EPROM: refused program enables, group loading, stuck program bit, clear.
    wr(CTRL, cv(0, 1, 0, 0, 0));
    rdchk(CTRL, 32'h0, "program without latch");
    wr(CTRL, cv(1, 0, 0, 0, 0));
    wr(CTRL, cv(1, 1, 0, 0, 0));
    rdchk(CTRL, cv(1, 0, 0, 0, 0), "program without byte");
    chk(eprom_vector_ok_o, 1'b0, "vectors while latched");
    eprom_rdata_i <= $urandom;
    rdchk(EPD, 32'hff, "eprom latched read");
    ga = $urandom;
    pd = '0;
    for (i = 0; i < 17; i++) begin
      a = (i < 16) ? {ga[15:4], i[3:0]} : (ga ^ 16'h0010);
      d = $urandom;
      wr(EPA, {16'h0, a});
      wr(EPD, {24'h0, d});
      if (i < 16) pd[8*i +: 8] = d;
    end
    wr(CTRL, cv(1, 1, 0, 0, 0));
    rdchk(CTRL, cv(1, 1, 0, 0, 0), "programming state");
    chk(eprom_program_enable_o, 1'b1, "program enable");
    chk(eprom_prog_addr_o, {ga[15:4], 4'h0}, "group address");
    chk(eprom_prog_data_o, pd, "group data");
    wr(CTRL, cv(1, 0, 0, 0, 0));
    rdchk(CTRL, cv(1, 1, 0, 0, 0), "zero to program bit");
    wr(CTRL, 32'h0);
    rdchk(CTRL, 32'h0, "latch cleared");
    chk(eprom_program_enable_o, 1'b0, "program off");
    chk(eprom_prog_data_o, 128'h0, "buffer erased");
    rv = $urandom;
    eprom_rdata_i <= rv;
    rdchk(EPD, {24'h0, rv}, "eprom normal read");
    chk(eprom_rd_addr_o, ga ^ 16'h0010, "read address");
    chk(eprom_vector_ok_o, 1'b1, "vectors in read mode");
    $display("test eprom done");
    // EEPROM program and erase: select frozen after capture, pump held until latch clear.
    for (e = 0; e < 2; e++) begin
      wr(CTRL, cv(0, 0, !e[0], 1, 0));
      wr(CTRL, cv(0, 0, e[0], 1, 1));
      rdchk(CTRL, cv(0, 0, e[0], 1, 0), "load state");
      a = $urandom;
      d = $urandom;
      wr(EEA, {16'h0, a});
      wr(EED, {24'h0, d});
      wr(CTRL, cv(0, 0, !e[0], 1, 0));
      rdchk(CTRL, cv(0, 0, e[0], 1, 0), "select frozen");
      chk(eeprom_target_o, {a, d}, "eeprom target");
      wr(CTRL, cv(0, 0, e[0], 1, 1));
      rdchk(CTRL, cv(0, 0, e[0], 1, 1), "pump state");
      chk(eeprom_pump_enable_o, 1'b1, "pump on");
      chk(eeprom_erase_select_o, e[0], "operation select");
      wr(CTRL, cv(0, 0, e[0], 1, 0));
      rdchk(CTRL, cv(0, 0, e[0], 1, 1), "pump stuck");
      rdchk(EED, 32'hff, "eeprom latched read");
      wr(CTRL, 32'h0);
      rdchk(CTRL, 32'h0, "eeprom cleared");
      chk(eeprom_pump_enable_o, 1'b0, "pump off");
    end
    rv = $urandom;
    eeprom_rdata_i <= rv;
    rdchk(EED, {24'h0, rv}, "eeprom normal read");
    $display("test eeprom done");
    // A STOP pulse that falls wholly inside a frozen clock enable is never seen.
    wr(CTRL, cv(1, 0, 0, 1, 0));
    ce_i <= 1'b0;
    stop_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    stop_i <= 1'b0;
    @(posedge clk_i);
    ce_i <= 1'b1;
    rdchk(CTRL, cv(1, 0, 0, 1, 0), "clock enable freeze");
    $display("test freeze done");
    // Stop, power-on and pin reset events each clear both latches; option byte stays.
    for (i = 0; i < 3; i++) begin
      wr(CTRL, cv(1, 0, 0, 1, 0));
      {stop_i, por_i, ext_reset_i} <= 3'b100 >> i;
      repeat (6) @(posedge clk_i);
      {stop_i, por_i, ext_reset_i} <= 3'b000;
      rdchk(CTRL, 32'h0, "event clears latches");
      rdchk(OPT, {24'h0, ob}, "option after event");
    end
    $display("test events done");
    summarize();
  end

endmodule
